// ==== rtl/cdoc_defines.svh ====
// Register offsets, reset values and timing counts for the clock control
// Overview of operation
// - Doubler register bits 7:3 are ignored
// - Doubler code zero passes undoubled main clock
// - Nonzero code selects low time, 111 longest
// - Doubled clock: main XOR delayed inverted copy
// - Only write strobes use the falling edge
// - Fetch wait states selectable 0, 1, 2, 4
// - Turning doubler off halves processor and peripheral, except when run from 32 kHz
// - Processor alone or both divide by eight
// - Both clocks may run from 32 kHz oscillator
// - Clock pin: clock, clock/2, low, high
// - Status pin: fetch, int ack, low, high
// - Bit 3 forces watchdog pin low
// - Forced low lasts one to two 32k periods
// - Output control bit 2 has no effect
// - Buffer enable: I/O, data memory, low, high
// - Clock select bits 4:2 choose clock sources
// - Doubler with divide by eight nets four
`ifndef CDOC_DEFINES_SVH
`define CDOC_DEFINES_SVH

// Register indices; byte address is four times the index
`define CDOC_IDX_GCS 6'h00
`define CDOC_IDX_OPC 6'h0e
`define CDOC_IDX_CDC 6'h0f
`define CDOC_IDX_PWR 6'h10
`define CDOC_IDX_STAT 6'h11

`define CDOC_RST_GCS 3'h0
`define CDOC_RST_OPC 8'h00
`define CDOC_RST_CDC 3'h0
`define CDOC_RST_PWR 2'h0

// Global clock select field position
`define CDOC_GCS_LSB 2
`define CDOC_GCS_MSB 4

`define CDOC_CLK_NS 8
`define CDOC_LOW_NS_1 8
`define CDOC_LOW_NS_2 10
`define CDOC_LOW_NS_3 2
`define CDOC_LOW_NS_4 4
`define CDOC_LOW_NS_5 6
`define CDOC_LOW_NS_6 18
`define CDOC_LOW_NS_7 20
// Least time rounds up to whole cycles
`define CDOC_NS2CYC(t) (((t) + `CDOC_CLK_NS - 1) / `CDOC_CLK_NS)

`define CDOC_DIV8_HALF 4
`define CDOC_DIV2_HALF 1

`endif

// ==== rtl/cdoc_div.sv ====
// Tick driven clock divider with level and rising edge outputs
`timescale 1ns/1ns
`default_nettype none
module cdoc_div #(
  parameter int HALF = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  output logic clk_o,
  output logic rise_o
);
  logic [3:0] cnt_r;
  wire last = (cnt_r == 4'(HALF - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
      clk_o <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      rise_o <= tick_i & last & ~clk_o;
      if (tick_i) begin
        cnt_r <= last ? 4'h0 : cnt_r + 4'h1;
        if (last) begin
          clk_o <= ~clk_o;
        end
      end
    end
  end
endmodule : cdoc_div
`default_nettype wire

// ==== rtl/cdoc_pkg.sv ====
// Types shared by the clock control design
package cdoc_pkg;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic [1:0] status_sel;
    logic wd_force;
    logic spare;
    logic [1:0] buffer_sel;
  } cdoc_opc_s;

  typedef enum logic [1:0] {
    CDOC_SRC_DIV8,
    CDOC_SRC_MAIN,
    CDOC_SRC_32K
  } cdoc_src_e;

  typedef enum logic [1:0] {
    CDOC_WD_IDLE,
    CDOC_WD_WAIT1,
    CDOC_WD_WAIT2
  } cdoc_wd_e;

endpackage : cdoc_pkg

// ==== rtl/cdoc_top.sv ====
// Clock doubler, clock select and output pin control with Wishbone slave
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "cdoc_defines.svh"
module cdoc_top
  import cdoc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic main_osc_i,
  input wire logic osc32k_i,
  input wire logic opcode_fetch_i,
  input wire logic int_ack_i,
  input wire logic ext_io_cycle_i,
  input wire logic data_mem_access_i,
  input wire logic watchdog_in_n_i,
  input wire logic mem_write_req_i,
  input wire logic io_write_req_i,
  output logic proc_clk_o,
  output logic periph_clk_o,
  output logic main_osc_stop_o,
  output logic [2:0] fetch_wait_states_o,
  output logic clk_pin_o,
  output logic status_n_o,
  output logic watchdog_out_n_o,
  output logic bus_buffer_enable_n_o,
  output logic mem_write_n_o,
  output logic io_write_n_o
);

  localparam logic [1:0] LC1 = 2'(`CDOC_NS2CYC(`CDOC_LOW_NS_1));
  localparam logic [1:0] LC2 = 2'(`CDOC_NS2CYC(`CDOC_LOW_NS_2));
  localparam logic [1:0] LC3 = 2'(`CDOC_NS2CYC(`CDOC_LOW_NS_3));
  localparam logic [1:0] LC4 = 2'(`CDOC_NS2CYC(`CDOC_LOW_NS_4));
  localparam logic [1:0] LC5 = 2'(`CDOC_NS2CYC(`CDOC_LOW_NS_5));
  localparam logic [1:0] LC6 = 2'(`CDOC_NS2CYC(`CDOC_LOW_NS_6));
  localparam logic [1:0] LC7 = 2'(`CDOC_NS2CYC(`CDOC_LOW_NS_7));

  // Pin synchronisers; first stages feed only the second
  logic osc_m1_r, osc_m2_r, osc_m3_r;
  logic osc_k1_r, osc_k2_r, osc_k3_r;

  // Software written values and the copies in force
  logic [2:0] gcs_wr_r, gcs_r;
  cdoc_opc_s opc_wr_r, opc_r;
  logic [2:0] cdc_wr_r, cdc_r;
  logic [1:0] pwr_r;
  logic pend_r, wd_pend_r;
  cdoc_wd_e wd_state_r;

  logic ack_r;
  logic [31:0] rdata_r;
  logic fclk_r, fast_tick_r;
  logic [1:0] low_cnt_r;
  logic proc_clk_r, periph_clk_r, proc_tick_r, periph_tick_r;
  logic div8_clk, div8_rise, ph2_clk;

  // Bus decode
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire aligned = (wb_adr_i[1:0] == 2'h0);
  wire hit_gcs = aligned & (wb_adr_i[7:2] == `CDOC_IDX_GCS);
  wire hit_opc = aligned & (wb_adr_i[7:2] == `CDOC_IDX_OPC);
  wire hit_cdc = aligned & (wb_adr_i[7:2] == `CDOC_IDX_CDC);
  wire hit_pwr = aligned & (wb_adr_i[7:2] == `CDOC_IDX_PWR);
  wire hit_stat = aligned & (wb_adr_i[7:2] == `CDOC_IDX_STAT);
  wire wr_gcs = wb_wr & hit_gcs;
  wire wr_opc = wb_wr & hit_opc;
  wire wr_cdc = wb_wr & hit_cdc;
  wire wr_pwr = wb_wr & hit_pwr;
  wire wr_any = wr_gcs | wr_opc | wr_cdc;
  wire [2:0] gcs_field = wb_dat_i[`CDOC_GCS_MSB:`CDOC_GCS_LSB];

  // Status word: live clock state and settings in force
  wire wd_forcing = (wd_state_r != CDOC_WD_IDLE);
  wire [31:0] stat_word = {14'h0000, pwr_r, opc_r,
                           pend_r, wd_forcing, gcs_r, cdc_r};
  wire [31:0] rd_mux = hit_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      rdata_r <= rd_mux;
    end
  end

  // Edge of either polarity on the main oscillator
  wire main_edge = osc_m2_r ^ osc_m3_r;
  wire k_rise = osc_k2_r & ~osc_k3_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_m1_r <= 1'b0;
      osc_m2_r <= 1'b0;
      osc_m3_r <= 1'b0;
      osc_k1_r <= 1'b0;
      osc_k2_r <= 1'b0;
      osc_k3_r <= 1'b0;
    end else begin
      osc_m1_r <= main_osc_i;
      osc_m2_r <= osc_m1_r;
      osc_m3_r <= osc_m2_r;
      osc_k1_r <= osc32k_i;
      osc_k2_r <= osc_k1_r;
      osc_k3_r <= osc_k2_r;
    end
  end

  // Low time of the doubled clock per delay code
  logic [1:0] low_cyc;
  always_comb begin
    case (cdc_r)
      3'h1: low_cyc = LC1;
      3'h2: low_cyc = LC2;
      3'h3: low_cyc = LC3;
      3'h4: low_cyc = LC4;
      3'h5: low_cyc = LC5;
      3'h6: low_cyc = LC6;
      3'h7: low_cyc = LC7;
      default: low_cyc = 2'h1;
    endcase
  end

  // With the doubler on, every main edge opens a low gap, giving two pulses per period
  wire dbl_on = (cdc_r != 3'h0);
  wire low_done = (low_cnt_r == 2'h0);
  wire fclk_nxt = !dbl_on ? osc_m3_r :
                  main_edge ? 1'b0 :
                  low_done ? 1'b1 : 1'b0;
  wire [1:0] low_cnt_nxt = main_edge ? 2'(low_cyc - 2'h1) :
                           low_done ? 2'h0 : 2'(low_cnt_r - 2'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fclk_r <= 1'b0;
      fast_tick_r <= 1'b0;
      low_cnt_r <= 2'h0;
    end else begin
      fclk_r <= fclk_nxt;
      fast_tick_r <= fclk_nxt & ~fclk_r;
      low_cnt_r <= low_cnt_nxt;
    end
  end

  // Doubled or plain clock divided by eight; doubled nets four
  cdoc_div #(
    .HALF(`CDOC_DIV8_HALF)
  ) u_div8 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(fast_tick_r),
    .clk_o(div8_clk),
    .rise_o(div8_rise)
  );

  // Clock source per select code; main and divide by eight sources follow fclk
  // so doubler removal halves both clocks unless 32k is selected
  wire proc_32k = gcs_r[2];
  wire per_32k = gcs_r[2];
  wire proc_div8 = (gcs_r[2:1] == 2'b00);
  wire per_div8 = (gcs_r == 3'b000);
  cdoc_src_e proc_src, per_src;
  assign proc_src = proc_32k ? CDOC_SRC_32K :
                    proc_div8 ? CDOC_SRC_DIV8 : CDOC_SRC_MAIN;
  assign per_src = per_32k ? CDOC_SRC_32K :
                   per_div8 ? CDOC_SRC_DIV8 : CDOC_SRC_MAIN;

  logic proc_lvl, proc_rise, per_lvl, per_rise;
  always_comb begin
    case (proc_src)
      CDOC_SRC_32K: begin
        proc_lvl = osc_k2_r;
        proc_rise = k_rise;
      end
      CDOC_SRC_DIV8: begin
        proc_lvl = div8_clk;
        proc_rise = div8_rise;
      end
      default: begin
        proc_lvl = fclk_r;
        proc_rise = fast_tick_r;
      end
    endcase
    case (per_src)
      CDOC_SRC_32K: begin
        per_lvl = osc_k2_r;
        per_rise = k_rise;
      end
      CDOC_SRC_DIV8: begin
        per_lvl = div8_clk;
        per_rise = div8_rise;
      end
      default: begin
        per_lvl = fclk_r;
        per_rise = fast_tick_r;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      proc_clk_r <= 1'b0;
      periph_clk_r <= 1'b0;
      proc_tick_r <= 1'b0;
      periph_tick_r <= 1'b0;
    end else begin
      proc_clk_r <= proc_lvl;
      periph_clk_r <= per_lvl;
      proc_tick_r <= proc_rise;
      periph_tick_r <= per_rise;
    end
  end

  cdoc_div #(
    .HALF(`CDOC_DIV2_HALF)
  ) u_div2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(periph_tick_r),
    .clk_o(ph2_clk),
    .rise_o()
  );

  // Clock select, output and doubler writes land in staging registers and take effect on the
  // next processor clock edge; a write in that cycle stays pending
  wire apply = proc_tick_r & pend_r;
  wire pend_nxt = wr_any | (pend_r & ~proc_tick_r);
  wire wd_pend_nxt = (wr_opc & wb_dat_i[3]) |
                     (wd_pend_r & ~proc_tick_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gcs_wr_r <= `CDOC_RST_GCS;
      opc_wr_r <= `CDOC_RST_OPC;
      cdc_wr_r <= `CDOC_RST_CDC;
      pwr_r <= `CDOC_RST_PWR;
      pend_r <= 1'b0;
      wd_pend_r <= 1'b0;
    end else begin
      if (wr_gcs) begin
        gcs_wr_r <= gcs_field;
      end
      if (wr_opc) begin
        opc_wr_r <= cdoc_opc_s'(wb_dat_i[7:0]);
      end
      if (wr_cdc) begin
        cdc_wr_r <= wb_dat_i[2:0];
      end
      if (wr_pwr) begin
        pwr_r <= wb_dat_i[1:0];
      end
      pend_r <= pend_nxt;
      wd_pend_r <= wd_pend_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gcs_r <= `CDOC_RST_GCS;
      opc_r <= `CDOC_RST_OPC;
      cdc_r <= `CDOC_RST_CDC;
    end else if (apply) begin
      gcs_r <= gcs_wr_r;
      opc_r <= opc_wr_r;
      cdc_r <= cdc_wr_r;
    end
  end

  // Forced watchdog low ends on the second 32k rising edge
  wire wd_start = proc_tick_r & wd_pend_r;
  cdoc_wd_e wd_state_nxt;
  always_comb begin
    case (wd_state_r)
      CDOC_WD_IDLE: wd_state_nxt = wd_start ? CDOC_WD_WAIT1 : CDOC_WD_IDLE;
      CDOC_WD_WAIT1: wd_state_nxt = k_rise ? CDOC_WD_WAIT2 : CDOC_WD_WAIT1;
      CDOC_WD_WAIT2: wd_state_nxt = k_rise ? CDOC_WD_IDLE : CDOC_WD_WAIT2;
      default: wd_state_nxt = CDOC_WD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_state_r <= CDOC_WD_IDLE;
    end else begin
      wd_state_r <= wd_state_nxt;
    end
  end

  // Pin selections; bit 2 of the output control drives no pin
  logic clk_pin_nxt, status_nxt, buffer_nxt;
  always_comb begin
    case (opc_r.clk_sel)
      2'b00: clk_pin_nxt = periph_clk_r;
      2'b01: clk_pin_nxt = ph2_clk;
      2'b10: clk_pin_nxt = 1'b0;
      default: clk_pin_nxt = 1'b1;
    endcase
    case (opc_r.status_sel)
      2'b00: status_nxt = ~opcode_fetch_i;
      2'b01: status_nxt = ~int_ack_i;
      2'b10: status_nxt = 1'b0;
      default: status_nxt = 1'b1;
    endcase
    case (opc_r.buffer_sel)
      2'b00: buffer_nxt = ~ext_io_cycle_i;
      2'b01: buffer_nxt = ~data_mem_access_i;
      2'b10: buffer_nxt = 1'b0;
      default: buffer_nxt = 1'b1;
    endcase
  end

  wire wd_nxt = wd_forcing ? 1'b0 : watchdog_in_n_i;
  // Strobes only in the low phase, as a falling edge timed pulse
  wire mem_wr_nxt = ~(mem_write_req_i & ~proc_lvl);
  wire io_wr_nxt = ~(io_write_req_i & ~proc_lvl);
  logic [2:0] wait_nxt;
  always_comb begin
    case (pwr_r)
      2'b00: wait_nxt = 3'h0;
      2'b01: wait_nxt = 3'h1;
      2'b10: wait_nxt = 3'h2;
      default: wait_nxt = 3'h4;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_pin_o <= 1'b0;
      status_n_o <= 1'b1;
      watchdog_out_n_o <= 1'b1;
      bus_buffer_enable_n_o <= 1'b1;
      mem_write_n_o <= 1'b1;
      io_write_n_o <= 1'b1;
      fetch_wait_states_o <= 3'h0;
      main_osc_stop_o <= 1'b0;
    end else begin
      clk_pin_o <= clk_pin_nxt;
      status_n_o <= status_nxt;
      watchdog_out_n_o <= wd_nxt;
      bus_buffer_enable_n_o <= buffer_nxt;
      mem_write_n_o <= mem_wr_nxt;
      io_write_n_o <= io_wr_nxt;
      fetch_wait_states_o <= wait_nxt;
      main_osc_stop_o <= gcs_r[2] & gcs_r[0];
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign proc_clk_o = proc_clk_r;
  assign periph_clk_o = periph_clk_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_long_edge;
    (cdc_r == 3'h7) && main_edge && !pend_r;
  endsequence
  sequence seq_long_gap;
    !fclk_r [*3];
  endsequence

  AST_HIGH_BITS_IGNORED: assert property (
    wr_cdc |=> cdc_wr_r == $past(wb_dat_i[2:0]))
    else $error("doubler field not taken from low bits");
  AST_BYPASS: assert property (
    (cdc_r == 3'h0) && !pend_r |=> fclk_r == $past(osc_m3_r))
    else $error("disabled doubler does not pass main clock");
  AST_LONGEST_LOW: assert property (
    seq_long_edge |=> seq_long_gap)
    else $error("longest code low time too short");
  AST_TWO_PULSES: assert property (
    seq_long_edge ##1 seq_long_gap |-> ##[1:2] fast_tick_r)
    else $error("no doubled pulse after main edge");
  AST_STROBE_LOW_PHASE: assert property (
    !mem_write_n_o |-> $past(!proc_lvl))
    else $error("memory write strobe outside low phase");
  AST_FOUR_WAITS: assert property (
    pwr_r == 2'b11 |=> fetch_wait_states_o == 3'h4)
    else $error("wait state code 11 not four");
  AST_APPLY_ON_EDGE: assert property (
    apply && !wr_any |=> opc_r == $past(opc_wr_r) && !pend_r)
    else $error("staged value not applied at processor edge");
  AST_CLK_PIN_LOW: assert property (
    opc_r.clk_sel == 2'b10 |=> !clk_pin_o)
    else $error("clock pin not low for code 10");
  AST_WD_HELD: assert property (
    wd_start |=> ##1 (!watchdog_out_n_o && wd_forcing) [*2])
    else $error("forced watchdog low not held");
  AST_OSC_STOP: assert property (
    (gcs_r == 3'b101) |=> main_osc_stop_o && $past(per_32k))
    else $error("main oscillator not stopped for code 1x1");

endmodule : cdoc_top
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the clock doubler and output pin control
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic main_osc = 1'b0;
  logic osc32k = 1'b0;
  logic fetch = 1'b0;
  logic iack = 1'b0;
  logic extio = 1'b0;
  logic dmem = 1'b0;
  logic wd_in_n = 1'b1;
  logic mreq = 1'b0;
  logic ioreq = 1'b0;
  logic proc_clk, periph_clk, osc_stop, clk_pin, status_n, wd_out_n;
  logic buffer_n, mem_wr_n, io_wr_n;
  logic [2:0] waits;
  int failures = 0;
  int checked = 0;
  int mcnt = 0;
  int pr, pe, cp, wl, ml, il;
  // Pin mode table: written byte, {fetch,iack,extio,dmem}, {clk,st,buf}
  logic [7:0] opc_tab [7] = '{8'ha4, 8'hf3, 8'hb2, 8'h81, 8'h81, 8'h90,
                              8'h94};
  logic [3:0] in_tab [7] = '{4'h2, 4'hf, 4'hf, 4'h9, 4'h6, 4'h4, 4'ha};
  logic [2:0] exp_tab [7] = '{3'h0, 3'h7, 3'h2, 3'h0, 3'h3, 3'h1, 3'h2};
  // Clock table; rises counted over 320 cycles, main osc period 20
  logic [7:0] gcs_tab [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h00, 8'h08,
                              8'h10, 8'h14};
  logic [7:0] cdc_tab [8] = '{8'h00, 8'hf8, 8'h00, 8'h01, 8'h09, 8'hff,
                              8'h00, 8'h00};
  int pr_tab [8] = '{2, 2, 16, 32, 4, 32, 8, 8};
  int pe_tab [8] = '{2, 16, 16, 32, 4, 32, 8, 8};
  logic [2:0] ws_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h4};

  always #4 clk_i = ~clk_i;

  // Main osc half period 10 cycles, 32k half period 20: slow enough to sync
  always @(posedge clk_i) begin
    mcnt <= (mcnt == 39) ? 0 : mcnt + 1;
    if (mcnt % 10 == 9) main_osc <= ~main_osc;
    if (mcnt % 20 == 19) osc32k <= ~osc32k;
  end

  cdoc_top cdoc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .main_osc_i(main_osc),
    .osc32k_i(osc32k), .opcode_fetch_i(fetch), .int_ack_i(iack),
    .ext_io_cycle_i(extio), .data_mem_access_i(dmem),
    .watchdog_in_n_i(wd_in_n), .mem_write_req_i(mreq),
    .io_write_req_i(ioreq), .proc_clk_o(proc_clk),
    .periph_clk_o(periph_clk), .main_osc_stop_o(osc_stop),
    .fetch_wait_states_o(waits), .clk_pin_o(clk_pin),
    .status_n_o(status_n), .watchdog_out_n_o(wd_out_n),
    .bus_buffer_enable_n_o(buffer_n), .mem_write_n_o(mem_wr_n),
    .io_write_n_o(io_wr_n)
  );

  task automatic give_verdict;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_range(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : cmp_range

  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // Staged values only land on a processor clock edge
  task automatic wait_apply;
    int n;
    n = 0;
    do begin
      wb(1'b0, 8'h44, 32'h0, 4'hf);
      n++;
    end while (rd[7] !== 1'b0 && n < 200);
    cmp({31'h0, rd[7]}, 32'h0);
    repeat (2) @(posedge clk_i);
  endtask : wait_apply

  task automatic count(input int span);
    logic lp, le, lc;
    pr = 0; pe = 0; cp = 0; wl = 0; ml = 0; il = 0;
    lp = proc_clk; le = periph_clk; lc = clk_pin;
    repeat (span) begin
      @(posedge clk_i);
      if (proc_clk === 1'b1 && lp === 1'b0) pr++;
      if (periph_clk === 1'b1 && le === 1'b0) pe++;
      if (clk_pin === 1'b1 && lc === 1'b0) cp++;
      if (wd_out_n === 1'b0) wl++;
      if (mem_wr_n === 1'b0) ml++;
      if (io_wr_n === 1'b0) il++;
      lp = proc_clk; le = periph_clk; lc = clk_pin;
    end
  endtask : count

  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    cmp({26'h0, status_n, wd_out_n, buffer_n, mem_wr_n, io_wr_n, clk_pin},
        32'h3e);
    rst_i <= 1'b0;
    wb(1'b0, 8'h44, 32'h0, 4'hf);
    cmp(rd, 32'h0);
    wb(1'b1, 8'h00, 32'h08, 4'hf);
    wait_apply();
    // Unmapped, misaligned and lane-less writes are all dropped
    wb(1'b1, 8'h80, 32'hff, 4'hf);
    wb(1'b0, 8'h80, 32'h0, 4'hf);
    cmp(rd, 32'h0);
    wb(1'b1, 8'h3d, 32'h07, 4'hf);
    wb(1'b1, 8'h3c, 32'h07, 4'he);
    wait_apply();
    cmp({29'h0, rd[2:0]}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_i);
      {fetch, iack, extio, dmem} <= in_tab[i];
      wb(1'b1, 8'h38, {24'h0, opc_tab[i]}, 4'hf);
      wait_apply();
      cmp({29'h0, clk_pin, status_n, buffer_n}, {29'h0, exp_tab[i]});
    end
    wb(1'b1, 8'h38, 32'h00, 4'hf);
    wait_apply();
    count(320);
    cmp_range(cp, 15, 17);
    wb(1'b1, 8'h38, 32'h40, 4'hf);
    wait_apply();
    count(320);
    cmp_range(cp, 7, 9);
    // Forced low is a one-shot; a stuck level would fill the window
    wb(1'b1, 8'h38, 32'h08, 4'hf);
    count(300);
    cmp_range(wl, 40, 84);
    wb(1'b1, 8'h38, 32'h00, 4'hf);
    wait_apply();
    wd_in_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp({31'h0, wd_out_n}, 32'h0);
    wd_in_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    cmp({31'h0, wd_out_n}, 32'h1);
    mreq <= 1'b1;
    ioreq <= 1'b1;
    count(40);
    cmp_range(ml, 15, 25);
    cmp_range(il, 15, 25);
    mreq <= 1'b0;
    ioreq <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'h40, i, 4'hf);
      repeat (2) @(posedge clk_i);
      cmp({29'h0, waits}, {29'h0, ws_tab[i]});
    end
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, 8'h3c, {24'h0, cdc_tab[i]}, 4'hf);
      wb(1'b1, 8'h00, {24'h0, gcs_tab[i]}, 4'hf);
      wait_apply();
      cmp({26'h0, rd[5:0]}, {26'h0, gcs_tab[i][4:2], cdc_tab[i][2:0]});
      repeat (200) @(posedge clk_i);
      count(320);
      cmp_range(pr, pr_tab[i] - 1, pr_tab[i] + 1);
      cmp_range(pe, pe_tab[i] - 1, pe_tab[i] + 1);
      cmp({31'h0, osc_stop}, {31'h0, i == 7});
    end
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
